// *** ftc_top.sv ***
// ftc_top: floating-point trap capture registers with register port
// assumes datapath reports and register strobes are on ref_clk
// Functional notes
// - store input rounding mode in two-bit field on capture
// - flag-update instruction: capture the rounding mode before its update
// - writing one to clear bit drops valid status; zero ignored; reads zero
// - valid clear: next enabled exception captures details and sets status
// - valid set: further exceptions ignored, contents frozen
// - capture full 32-bit program counter, read-only
// - capture four-bit destination data register index
// - capture format bit, zero three-register, one two-register
// - capture eight-bit secondary opcode
// - three-register format: only low four opcode bits defined
// - capture 32-bit first source operand, read-only
// - trap only for exception types whose enable bit is set
// - no further coprocessor error traps while status stays set
// - signal trap only after instruction completes; result untouched
// - latch the five exception flags of captured instruction
`timescale 1ns/1ps
`default_nettype none
module ftc_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ftc_pkg::ftc_report_t report,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic coprocessor_async_error,
  output logic irq
);

  typedef struct packed {
    ftc_pkg::ftc_flags_t enables;
    logic [31:0] rdata;
    logic trap;
  } ftc_top_state_t;

  ftc_top_state_t s_q;
  ftc_top_state_t s_d;
  ftc_pkg::ftc_bus_t bus;
  ftc_pkg::ftc_capture_t cap;
  logic cap_pulse;
  logic trap_clear;
  logic [ftc_pkg::IRQ_W-1:0] irq_status;
  logic [ftc_pkg::IRQ_W-1:0] irq_mask;
  logic [ftc_pkg::IRQ_W-1:0] irq_clr;
  logic irq_mask_we;
  logic [31:0] ctrl_word;
  logic [31:0] opc_word;

  assign bus = '{wr: wr_en, rd: rd_en, addr: addr, wdata: wdata};

  // write-one on the clear bit of the control word
  assign trap_clear = bus.wr && bus.addr == ftc_pkg::CTRL_OFS &&
    bus.wdata[ftc_pkg::CLEAR_BIT];

  ftc_capture u_cap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .report(report),
    .enables(s_q.enables),
    .clear(trap_clear),
    .cap(cap),
    .capture_pulse(cap_pulse)
  );

  // interrupt bits: capture event and trap raised share the same cause
  assign irq_clr = (bus.wr && bus.addr == ftc_pkg::IRQ_STAT_OFS) ?
    bus.wdata[ftc_pkg::IRQ_W-1:0] : '0;
  assign irq_mask_we = bus.wr && bus.addr == ftc_pkg::IRQ_MASK_OFS;

  ftc_irq u_irq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .events({cap_pulse, cap_pulse}),
    .clr_mask(irq_clr),
    .mask_we(irq_mask_we),
    .mask_wdata(bus.wdata[ftc_pkg::IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // control word image; clear bit and reserved bits read zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[ftc_pkg::STATUS_BIT] = cap.capture_valid_status;
    ctrl_word[ftc_pkg::RM_LO +: 2] = cap.captured_round_mode;
    ctrl_word[ftc_pkg::ENA_LO +: 5] = s_q.enables;
    ctrl_word[ftc_pkg::FLAG_LO +: 5] = cap.flags;
  end

  // opcode word image
  always_comb begin
    opc_word = '0;
    opc_word[7:0] = cap.secondary_opcode_field;
    opc_word[ftc_pkg::FMT_BIT] = cap.instr_format_bit;
    opc_word[ftc_pkg::DEST_REG_INDEX_LO +: 4] = cap.dest_reg_index;
  end

  // register port; unmapped reads return zero, unmapped writes are dropped
  always_comb begin
    s_d = s_q;
    s_d.rdata = ftc_pkg::DATA_RST;
    if (bus.wr && bus.addr == ftc_pkg::CTRL_OFS) begin
      s_d.enables = bus.wdata[ftc_pkg::ENA_LO +: 5];
    end
    // writes to pc, opcode and operand words are not decoded
    if (bus.rd) begin
      case (bus.addr)
        ftc_pkg::CTRL_OFS: s_d.rdata = ctrl_word;
        ftc_pkg::PC_OFS: s_d.rdata = cap.pc;
        ftc_pkg::OPC_OFS: s_d.rdata = opc_word;
        ftc_pkg::FIRST_SOURCE_OPERAND_OFS: s_d.rdata = cap.first_source_operand;
        ftc_pkg::IRQ_STAT_OFS: s_d.rdata = {30'h0, irq_status};
        ftc_pkg::IRQ_MASK_OFS: s_d.rdata = {30'h0, irq_mask};
        default: s_d.rdata = ftc_pkg::DATA_RST;
      endcase
    end
    // one trap per capture, raised from the completed report only
    s_d.trap = cap_pulse;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '{enables: ftc_pkg::ENA_RST, rdata: ftc_pkg::DATA_RST,
               trap: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign coprocessor_async_error = s_q.trap;

endmodule
`default_nettype wire

// *** ftc_pkg.sv ***
// ftc_pkg: shared constants and carrier types for the fp trap capture block
// assumes a single core clock and a plain address/strobe register port
package ftc_pkg;

  // register byte offsets
  localparam logic [15:0] CTRL_OFS = 16'hA000;
  localparam logic [15:0] PC_OFS = 16'hA004;
  localparam logic [15:0] OPC_OFS = 16'hA008;
  localparam logic [15:0] FIRST_SOURCE_OPERAND_OFS = 16'hA010;
  localparam logic [15:0] IRQ_STAT_OFS = 16'hA020;
  localparam logic [15:0] IRQ_MASK_OFS = 16'hA024;

  // control register field positions
  localparam int STATUS_BIT = 0;
  localparam int CLEAR_BIT = 1;
  localparam int RM_LO = 8;
  localparam int ENA_LO = 18;
  localparam int FLAG_LO = 26;

  // opcode register field positions
  localparam int DEST_REG_INDEX_LO = 16;
  localparam int FMT_BIT = 8;

  // interrupt status bits
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_TRAP = 1;
  localparam int IRQ_W = 2;

  // reset values
  localparam logic [4:0] ENA_RST = 5'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // exception flags: invalid, overflow, divzero, underflow, inexact
  typedef struct packed {
    logic invalid;
    logic overflow;
    logic divzero;
    logic underflow;
    logic inexact;
  } ftc_flags_t;

  // completed instruction report from the fp datapath
  typedef struct packed {
    logic valid;
    ftc_flags_t flags;
    logic [31:0] pc;
    logic [3:0] dest_reg_index;
    logic instr_format_bit;
    logic [7:0] secondary_opcode_field;
    logic [31:0] first_source_operand;
    logic [1:0] input_round_mode;
  } ftc_report_t;

  // captured contents
  typedef struct packed {
    logic capture_valid_status;
    ftc_flags_t flags;
    logic [31:0] pc;
    logic [3:0] dest_reg_index;
    logic instr_format_bit;
    logic [7:0] secondary_opcode_field;
    logic [31:0] first_source_operand;
    logic [1:0] captured_round_mode;
  } ftc_capture_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ftc_bus_t;

endpackage

// *** ftc_capture.sv ***
// ftc_capture: holds the trapped instruction details and the valid flag
// assumes the report arrives after the instruction has completed
`timescale 1ns/1ps
`default_nettype none
module ftc_capture (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ftc_pkg::ftc_report_t report,
  input wire ftc_pkg::ftc_flags_t enables,
  input wire logic clear,
  output ftc_pkg::ftc_capture_t cap,
  output logic capture_pulse
);

  typedef struct packed {
    ftc_pkg::ftc_capture_t cap;
    logic pulse;
  } ftc_cap_state_t;

  ftc_cap_state_t s_q;
  ftc_cap_state_t s_d;
  logic hit;

  // only enabled exceptions count
  assign hit = report.valid && |(report.flags & enables);

  // capture when empty, freeze when full, clear on software request
  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!s_q.cap.capture_valid_status && hit) begin
      s_d.cap.capture_valid_status = 1'b1;
      s_d.cap.flags = report.flags;
      s_d.cap.pc = report.pc;
      s_d.cap.dest_reg_index = report.dest_reg_index;
      s_d.cap.instr_format_bit = report.instr_format_bit;
      // upper opcode bits are left as delivered for the three-reg format
      s_d.cap.secondary_opcode_field = report.secondary_opcode_field;
      s_d.cap.first_source_operand = report.first_source_operand;
      // input mode, not the mode a flag update may write back
      s_d.cap.captured_round_mode = report.input_round_mode;
      s_d.pulse = 1'b1;
    end else if (clear) begin
      s_d.cap.capture_valid_status = 1'b0;
    end
  end

  // reset clears the status and every data field
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cap = s_q.cap;
  assign capture_pulse = s_q.pulse;

endmodule
`default_nettype wire

// *** ftc_irq.sv ***
// ftc_irq: sticky event bits, mask and one level interrupt
// assumes events are single-cycle pulses on ref_clk
`timescale 1ns/1ps
`default_nettype none
module ftc_irq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ftc_pkg::IRQ_W-1:0] events,
  input wire logic [ftc_pkg::IRQ_W-1:0] clr_mask,
  input wire logic mask_we,
  input wire logic [ftc_pkg::IRQ_W-1:0] mask_wdata,
  output logic [ftc_pkg::IRQ_W-1:0] status,
  output logic [ftc_pkg::IRQ_W-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [ftc_pkg::IRQ_W-1:0] status;
    logic [ftc_pkg::IRQ_W-1:0] mask;
    logic irq;
  } ftc_irq_state_t;

  ftc_irq_state_t s_q;
  ftc_irq_state_t s_d;

  // set wins over a clear in the same cycle
  always_comb begin
    s_d = s_q;
    s_d.status = (s_q.status & ~clr_mask) | events;
    if (mask_we) begin
      s_d.mask = mask_wdata;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= {ftc_pkg::IRQ_RST, ftc_pkg::IRQ_RST, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign mask = s_q.mask;
  assign irq = s_q.irq;

endmodule
`default_nettype wire

// *** ftc_properties.sv ***
// ftc_properties: port-level checks of the fp trap capture top
// assumes it is bound onto ftc_top, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module ftc_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire ftc_pkg::ftc_report_t report,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic coprocessor_async_error,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] ena_q;
  logic st_q;
  ftc_pkg::ftc_report_t cap_q;
  logic hit, cwr, rc;
  assign cwr = wr_en && addr == ftc_pkg::CTRL_OFS;
  assign rc = rd_en && addr == ftc_pkg::CTRL_OFS;
  assign hit = report.valid && |(report.flags & ena_q) && !st_q;
  // shadow state; a clear beside a hit loses to the capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ena_q <= 5'h00;
      st_q <= 1'h0;
      cap_q <= '0;
    end else begin
      if (cwr) ena_q <= wdata[22:18];
      if (hit) cap_q <= report;
      st_q <= hit | (st_q & !(cwr & wdata[1]));
    end
  end
  chk_trap_after_hit: assert property (
    hit |-> ##2 coprocessor_async_error) else $error("trap missing");
  chk_trap_cause: assert property (
    coprocessor_async_error |-> $past(hit, 2)) else $error("stray trap");
  chk_trap_single: assert property (
    coprocessor_async_error |=> !coprocessor_async_error)
    else $error("trap too long");
  chk_status_read: assert property (
    rc |=> rdata[0] == $past(st_q)) else $error("status wrong");
  chk_clear_zero: assert property (
    rc |=> !rdata[1]) else $error("clear bit reads one");
  chk_ctrl_fields: assert property (
    rc |=> rdata[30:26] == $past(cap_q.flags) && rdata[22:18] ==
    $past(ena_q) && rdata[9:8] == $past(cap_q.input_round_mode))
    else $error("control fields wrong");
  chk_pc_read: assert property (
    rd_en && addr == ftc_pkg::PC_OFS |=> rdata == $past(cap_q.pc))
    else $error("pc wrong");
  chk_opc_read: assert property (
    rd_en && addr == ftc_pkg::OPC_OFS |=> rdata[19:0] ==
    {$past(cap_q.dest_reg_index), 7'h00, $past(cap_q.instr_format_bit),
    $past(cap_q.secondary_opcode_field)}) else $error("opcode wrong");
  chk_src_read: assert property (
    rd_en && addr == ftc_pkg::FIRST_SOURCE_OPERAND_OFS |=> rdata ==
    $past(cap_q.first_source_operand)) else $error("operand wrong");
endmodule
`default_nettype wire

// *** ftc_core_model.sv ***
// ftc_core_model: fp datapath stand-in reporting completed instructions
// assumes the bench calls send once per instruction
`timescale 1ns/1ps
`default_nettype none
module ftc_core_model (
  input wire logic ref_clk,
  output var ftc_pkg::ftc_report_t report
);
  initial report = '0;
  // one-cycle report; idle fields flip so stale data never looks held
  task automatic send(input ftc_pkg::ftc_report_t v);
    @(posedge ref_clk);
    report <= v;
    @(posedge ref_clk);
    report <= {1'h0, ~v[$bits(v)-2:0]};
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// tb_top: register-level test of the fp trap capture top
// assumes a 250 MHz ref_clk and the core model driving reports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] ctl = ftc_pkg::CTRL_OFS, pca = ftc_pkg::PC_OFS;
  localparam logic [15:0] opa = ftc_pkg::OPC_OFS, sra = ftc_pkg::FIRST_SOURCE_OPERAND_OFS;
  localparam logic [15:0] ist = 16'hA020, imk = 16'hA024;
  localparam logic [31:0] full = 32'hFFFF_FFFF;
  logic ref_clk, rst_n, wr_en, rd_en, coprocessor_async_error, irq;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  ftc_pkg::ftc_report_t report;
  int err_total, compares, traps, cyc;
  ftc_top ftc_top_inst (.ref_clk, .rst_n, .report, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .coprocessor_async_error, .irq);
  ftc_core_model ftc_core_model_inst (.ref_clk, .report);
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // count trap pulses; a hang ends the run as a mismatch
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (coprocessor_async_error === 1'h1) traps <= traps + 1;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end
  task automatic cmp32(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_en <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input string n, input logic [15:0] a,
    input logic [31:0] e, m);
    @(posedge ref_clk);
    rd_en <= 1'h1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'h0;
    #1;
    cmp32(n, e, rdata & m);
  endtask
  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 16'h0000;
    wdata = 32'h0000_0000;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd("ctrl", ctl, 32'h0000_0000, full);
    rd("hole", 16'hA00C, 32'h0000_0000, full);
    // nothing enabled yet, then only overflow enabled
    ftc_core_model_inst.send('{1, 5'h10, 0, 0, 0, 0, 0, 0});
    wr(ctl, 32'h0020_0000);
    wr(imk, 32'h0000_0003);
    ftc_core_model_inst.send('{1, 5'h04, 0, 0, 0, 0, 0, 0});
    ftc_core_model_inst.send('{1, 5'h09, 32'h8000_1234, 4'h5, 1, 8'hA5,
      32'hC0DE_0001, 2'h2});
    repeat (3) @(posedge ref_clk);
    #1;
    cmp32("traps", 1, traps);
    cmp32("irq", 1, {31'h0, irq});
    // held capture ignores a second hit and software writes
    ftc_core_model_inst.send('{1, 5'h08, full, 4'hE, 0, 8'h11, full,
      2'h3});
    wr(pca, full);
    wr(opa, full);
    wr(sra, full);
    rd("ctrl", ctl, 32'h2420_0201, full);
    rd("pc", pca, 32'h8000_1234, full);
    rd("opc", opa, 32'h0005_01A5, 32'h000F_01FF);
    rd("src", sra, 32'hC0DE_0001, full);
    cmp32("traps", 1, traps);
    wr(ctl, 32'h0020_0000);
    rd("ctrl", ctl, 32'h0000_0001, 32'h0000_0003);
    wr(ctl, 32'h0020_0002);
    rd("ctrl", ctl, 32'h2420_0200, full);
    wr(ist, 32'h0000_0003);
    #1;
    cmp32("irq", 0, {31'h0, irq});
    // masked second capture of a mode-changing instruction
    wr(imk, 32'h0000_0000);
    ftc_core_model_inst.send('{1, 5'h08, 0, 4'hF, 0, 8'h3C, 0, 2'h1});
    repeat (3) @(posedge ref_clk);
    #1;
    cmp32("irq", 0, {31'h0, irq});
    rd("istat", ist, 32'h0000_0003, full);
    rd("ctrl", ctl, 32'h2020_0101, full);
    rd("opc", opa, 32'h000F_000C, 32'h000F_010F);
    cmp32("traps", 2, traps);
    wr(imk, 32'h0000_0003);
    #1;
    cmp32("irq", 1, {31'h0, irq});
    test_done();
  end
endmodule
bind ftc_top ftc_properties ftc_properties_inst (.ref_clk, .rst_n,
  .report, .addr, .wdata, .wr_en, .rd_en, .rdata,
  .coprocessor_async_error, .irq);
`default_nettype wire
